/* hw/awsc_area_wait_ctrl.v */
// Area wait-state controller: holds the wait control fields of areas 1-4,
// the memory type of areas 1-3, and times each access to areas 1-4.
// Assumes the requester is on ref_clk; the wait pin is asynchronous.
`timescale 1ns/100ps
`include "awsc_consts.vh"
module awsc_area_wait_ctrl #(
	parameter ADDR_W = `AWSC_ADDR_W,
	parameter CNT_W = `AWSC_CNT_W,
	parameter EXT_W = `AWSC_EXT_W
) (
	input wire ref_clk,
	input wire reset,
	input wire clk_en,
	input wire [ADDR_W-1:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	input wire acc_req,
	input wire [2:0] acc_area,
	input wire ext_wait_n,
	output wire acc_ready,
	output wire acc_busy,
	output reg [CNT_W-1:0] acc_waits,
	output reg [1:0] acc_cas_period,
	output reg acc_mem_dram,
	output reg acc_wait_honoured
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;
	// A sized literal cannot be part-selected, so the reset code is named first
	localparam [3:0] TYPE_RST = `AWSC_TYPE_RESET;

	// Register fields
	reg [2:0] area4_wait_reg;
	reg [1:0] area3_wait_reg;
	reg [1:0] area12_wait_reg;
	reg [1:0] area3_type_reg;
	reg [1:0] area12_type_reg;

	// Access state
	reg state_reg;
	reg state_next;
	reg [2:0] cur_area_reg;
	reg [EXT_W-1:0] ext_cnt_reg;
	reg [EXT_W-1:0] ext_cnt_next;
	reg [EXT_W-1:0] last_ext_reg;
	reg [2:0] last_area_reg;
	reg last_dram_reg;

	// Wait pin synchroniser
	reg wait_meta_reg;
	reg wait_sync_reg;

	// Decode of the pending request
	reg [CNT_W-1:0] req_cycles;
	reg req_dram;
	reg req_wait_en;
	reg req_valid;
	reg [1:0] req_period;

	wire wr_ctrl;
	wire wr_type;
	wire start;
	wire hold;
	wire expired;
	wire [CNT_W-1:0] cnt_value;
	wire wait_asserted;

	assign wr_ctrl = reg_wr && (reg_addr == `AWSC_OFS_WAIT_CTRL);
	assign wr_type = reg_wr && (reg_addr == `AWSC_OFS_MEM_TYPE);

	// Two flops before anything looks at the asynchronous wait pin
	always @(posedge ref_clk) begin
		if (reset) begin
			wait_meta_reg <= 1'b0;
			wait_sync_reg <= 1'b0;
		end else if (clk_en) begin
			wait_meta_reg <= ~ext_wait_n;
			wait_sync_reg <= wait_meta_reg;
		end
	end
	assign wait_asserted = wait_sync_reg;

	// Field write and reset values
	always @(posedge ref_clk) begin
		if (reset) begin
			area4_wait_reg <= `AWSC_A4_RESET; // [R6]
			area3_wait_reg <= `AWSC_A3_RESET; // [R1] [R3]
			area12_wait_reg <= `AWSC_A12_RESET; // [R7]
		end else if (clk_en && wr_ctrl) begin
			area4_wait_reg <= reg_wdata[`AWSC_A4_HI:`AWSC_A4_LO]; // [R6]
			area3_wait_reg <= reg_wdata[`AWSC_A3_HI:`AWSC_A3_LO];
			area12_wait_reg <= reg_wdata[`AWSC_A12_HI:`AWSC_A12_LO]; // [R4]
		end
	end

	always @(posedge ref_clk) begin
		if (reset) begin
			area3_type_reg <= TYPE_RST[1:0];
			area12_type_reg <= TYPE_RST[3:2];
		end else if (clk_en && wr_type) begin
			area3_type_reg <= reg_wdata[1:0];
			area12_type_reg <= reg_wdata[3:2];
		end
	end

	// Normal-memory wait count for a two-bit field
	function [CNT_W-1:0] waits2;
		input [1:0] code;
		begin
			waits2 = {{(CNT_W-2){1'b0}}, code};
		end
	endfunction

	// Strobe period for DRAM-like memory: 00 and 01 both give one cycle
	function [1:0] period2;
		input [1:0] code;
		begin
			if (code == 2'h0) begin
				period2 = 2'h1;
			end else begin
				period2 = code;
			end
		end
	endfunction

	function [CNT_W-1:0] waits3;
		input [2:0] code;
		begin
			case (code)
				3'h0: waits3 = 4'h0;
				3'h1: waits3 = 4'h1;
				3'h2: waits3 = 4'h2;
				3'h3: waits3 = 4'h3;
				3'h4: waits3 = 4'h4;
				3'h5: waits3 = 4'h6;
				3'h6: waits3 = 4'h8;
				3'h7: waits3 = 4'ha;
				default: waits3 = 4'h0;
			endcase
		end
	endfunction

	// Area 3 knows four types; areas 1-2 have no pseudo-SRAM, so code 3 there
	// behaves as normal memory.
	always @* begin
		req_valid = 1'b1;
		req_dram = 1'b0;
		req_wait_en = 1'b0;
		req_period = 2'h0;
		req_cycles = {CNT_W{1'b0}};
		case (acc_area)
			`AWSC_AREA_1, `AWSC_AREA_2: begin
				// Both areas read the single shared field
				if (area12_type_reg == `AWSC_TYPE_DRAM || area12_type_reg == `AWSC_TYPE_SDRAM) begin // [R5]
					req_dram = 1'b1;
					req_period = period2(area12_wait_reg); // [R7] [R4]
					req_cycles = {{(CNT_W-2){1'b0}}, req_period};
				end else begin
					req_cycles = waits2(area12_wait_reg); // [R7] [R4]
					req_wait_en = (area12_wait_reg != 2'h0); // [R5]
				end
			end
			`AWSC_AREA_3: begin
				if (area3_type_reg != `AWSC_TYPE_NORMAL) begin // [R2]
					req_dram = 1'b1;
					req_period = period2(area3_wait_reg); // [R3]
					req_cycles = {{(CNT_W-2){1'b0}}, req_period};
				end else begin
					req_cycles = waits2(area3_wait_reg); // [R1]
					req_wait_en = (area3_wait_reg != 2'h0); // [R1] [R2]
				end
			end
			`AWSC_AREA_4: begin
				req_cycles = waits3(area4_wait_reg); // [R6]
				req_wait_en = (area4_wait_reg != 3'h0); // [R6]
			end
			default: begin
				// Areas 0, 5, 6 and 7 are timed elsewhere
				req_valid = 1'b0;
			end
		endcase
	end

	assign start = acc_req && req_valid && (state_reg == ST_IDLE);

	// The wait pin counts only when the running access honours it
	assign hold = acc_wait_honoured && wait_asserted; // [R1] [R2] [R5] [R6]

	awsc_wait_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.ref_clk(ref_clk),
		.reset(reset),
		.clk_en(clk_en),
		.load(start),
		.load_val(req_cycles),
		.active(state_reg == ST_RUN),
		.hold(hold),
		.count(cnt_value),
		.expired(expired)
	);

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (expired) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Cycles added by the wait pin, saturating so a stuck pin cannot wrap it
	always @* begin
		ext_cnt_next = ext_cnt_reg;
		if (start) begin
			ext_cnt_next = {EXT_W{1'b0}};
		end else if (state_reg == ST_RUN && cnt_value == {CNT_W{1'b0}} && hold &&
			ext_cnt_reg != {EXT_W{1'b1}}) begin
			ext_cnt_next = ext_cnt_reg + {{(EXT_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			cur_area_reg <= 3'h0;
			ext_cnt_reg <= {EXT_W{1'b0}};
			acc_waits <= {CNT_W{1'b0}};
			acc_cas_period <= 2'h0;
			acc_mem_dram <= 1'b0;
			acc_wait_honoured <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			ext_cnt_reg <= ext_cnt_next;
			if (start) begin
				cur_area_reg <= acc_area;
				acc_waits <= req_dram ? {CNT_W{1'b0}} : req_cycles;
				acc_cas_period <= req_period;
				acc_mem_dram <= req_dram;
				acc_wait_honoured <= req_wait_en;
			end
		end
	end

	// Summary of the most recent finished access
	always @(posedge ref_clk) begin
		if (reset) begin
			last_ext_reg <= {EXT_W{1'b0}};
			last_area_reg <= 3'h0;
			last_dram_reg <= 1'b0;
		end else if (clk_en && expired) begin
			last_ext_reg <= ext_cnt_reg;
			last_area_reg <= cur_area_reg;
			last_dram_reg <= acc_mem_dram;
		end
	end

	assign acc_ready = expired;
	assign acc_busy = (state_reg == ST_RUN);

	// Read data stand only in the cycle after the strobe; bits of the areas
	// not held here read as zero.
	always @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else if (clk_en) begin
			reg_rdata <= 16'h0000;
			if (reg_rd) begin
				case (reg_addr)
					`AWSC_OFS_WAIT_CTRL: begin
						reg_rdata[`AWSC_A4_HI:`AWSC_A4_LO] <= area4_wait_reg;
						reg_rdata[`AWSC_A3_HI:`AWSC_A3_LO] <= area3_wait_reg;
						reg_rdata[`AWSC_A12_HI:`AWSC_A12_LO] <= area12_wait_reg;
					end
					`AWSC_OFS_MEM_TYPE: begin
						reg_rdata[3:0] <= {area12_type_reg, area3_type_reg};
					end
					`AWSC_OFS_STATUS: begin
						reg_rdata[0] <= acc_busy;
						reg_rdata[1] <= acc_mem_dram;
						reg_rdata[2] <= acc_wait_honoured;
						reg_rdata[3] <= wait_asserted;
						reg_rdata[6:4] <= cur_area_reg;
						reg_rdata[11:8] <= cnt_value;
					end
					`AWSC_OFS_LAST: begin
						reg_rdata[7:0] <= last_ext_reg;
						reg_rdata[10:8] <= last_area_reg;
						reg_rdata[11] <= last_dram_reg;
					end
					default: begin
						reg_rdata <= 16'h0000;
					end
				endcase
			end
		end
	end
endmodule

/* hw/awsc_consts.vh */
// Constants for the area wait-state controller: register offsets, field
// positions, reset values, memory type codes and area codes.
// Assumes inclusion by bare name from the design files under hw/.
//
// Function
// [R1] Area 3 normal memory: codes 00-11 insert 0-3 waits; 00 ignores wait; reset 11.
// [R2] Area 3 wait input sampled only for normal memory, never for DRAM/SDRAM/PSRAM.
// [R3] Area 3 DRAM/SDRAM/PSRAM: codes 00-11 give 1,1,2,3 cycles; reset 11.
// [R4] One shared two-bit field at bits 4:3 serves both area 1 and area 2.
// [R5] Areas 1 and 2 honour wait input only as normal memory, not DRAM/SDRAM.
// [R6] Area 4 field bits 9:7 selects wait count; code 000 inserts none, ignores wait.
// [R7] Areas 1-2 field maps codes like area 3 in both modes; reset 11.
`ifndef AWSC_CONSTS_VH
`define AWSC_CONSTS_VH

`define AWSC_ADDR_W 4
`define AWSC_OFS_WAIT_CTRL 4'h0
`define AWSC_OFS_MEM_TYPE 4'h1
`define AWSC_OFS_STATUS 4'h2
`define AWSC_OFS_LAST 4'h3

`define AWSC_A4_HI 9
`define AWSC_A4_LO 7
`define AWSC_A3_HI 6
`define AWSC_A3_LO 5
`define AWSC_A12_HI 4
`define AWSC_A12_LO 3

`define AWSC_A4_RESET 3'h7
`define AWSC_A3_RESET 2'h3
`define AWSC_A12_RESET 2'h3
`define AWSC_TYPE_RESET 4'h0

`define AWSC_TYPE_NORMAL 2'h0
`define AWSC_TYPE_DRAM 2'h1
`define AWSC_TYPE_SDRAM 2'h2
`define AWSC_TYPE_PSRAM 2'h3

`define AWSC_AREA_1 3'h1
`define AWSC_AREA_2 3'h2
`define AWSC_AREA_3 3'h3
`define AWSC_AREA_4 3'h4

`define AWSC_CNT_W 4
`define AWSC_EXT_W 8

`endif

/* hw/awsc_wait_timer.v */
// Down counter that times one access: loaded with the cycle count, then held
// at zero while the wait input extends the access.
// Assumes load and hold come from logic on ref_clk.
`timescale 1ns/100ps
module awsc_wait_timer #(
	parameter CNT_W = 4
) (
	input wire ref_clk,
	input wire reset,
	input wire clk_en,
	input wire load,
	input wire [CNT_W-1:0] load_val,
	input wire active,
	input wire hold,
	output wire [CNT_W-1:0] count,
	output wire expired
);
	reg [CNT_W-1:0] cnt_reg;
	reg [CNT_W-1:0] cnt_next;

	always @* begin
		cnt_next = cnt_reg;
		if (load) begin
			cnt_next = load_val;
		end else if (active && cnt_reg != {CNT_W{1'b0}}) begin
			cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge ref_clk) begin
		if (reset) begin
			cnt_reg <= {CNT_W{1'b0}};
		end else if (clk_en) begin
			cnt_reg <= cnt_next;
		end
	end

	assign count = cnt_reg;
	// The wait input only stretches the access once the programmed waits ran out
	assign expired = active && (cnt_reg == {CNT_W{1'b0}}) && !hold;
endmodule

/* tb/area_wait_state_control_tb.sv */
// Self-checking bench: random field and type settings, accesses to areas 1-4.
// Assumes the memory model drives the wait pin; clk_en held high throughout.
`timescale 1ns/100ps
module area_wait_state_control_tb;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic acc_req = 1'b0;
	logic [2:0] acc_area = 3'h0;
	logic start = 1'b0;
	logic [3:0] hold = 4'h0;
	wire [15:0] reg_rdata;
	wire ext_wait_n, acc_ready, acc_busy, acc_mem_dram, acc_wait_honoured;
	wire [3:0] acc_waits;
	wire [1:0] acc_cas_period;
	integer n_errors = 0;
	integer n_checks = 0;
	integer i, a;
	logic [2:0] c4;
	logic [1:0] c3, c12, t3, t12;
	initial forever #25 ref_clk = ~ref_clk;
	awsc_mem_model mem (.ref_clk(ref_clk), .start(start), .hold(hold), .ext_wait_n(ext_wait_n));
	awsc_area_wait_ctrl DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.acc_req(acc_req), .acc_area(acc_area), .ext_wait_n(ext_wait_n), .acc_ready(acc_ready),
		.acc_busy(acc_busy), .acc_waits(acc_waits), .acc_cas_period(acc_cas_period),
		.acc_mem_dram(acc_mem_dram), .acc_wait_honoured(acc_wait_honoured));
	task chk(input [15:0] got, input [15:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input [3:0] ad, input [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input [3:0] ad, input [15:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	function [3:0] a4_waits(input [2:0] c);
		a4_waits = (c < 3'h4) ? {1'b0, c} : {c - 3'h2, 1'b0};
	endfunction
	task acc(input [2:0] ar, input [3:0] h);
		logic d;
		logic [1:0] c, p;
		logic [3:0] w, n;
		c = (ar == 3'h3) ? c3 : c12;
		d = (ar == 3'h3) ? (t3 != 2'h0) : (ar != 3'h4) && (t12 == 2'h1 || t12 == 2'h2);
		w = d ? 4'h0 : (ar == 3'h4) ? a4_waits(c4) : {2'h0, c};
		p = d ? ((c == 2'h0) ? 2'h1 : c) : 2'h0;
		@(posedge ref_clk);
		acc_req <= 1'b1;
		acc_area <= ar;
		start <= 1'b1;
		hold <= h;
		@(posedge ref_clk);
		acc_req <= 1'b0;
		start <= 1'b0;
		#1;
		chk(acc_waits, w);
		chk(acc_mem_dram, d);
		chk(acc_wait_honoured, !d && w != 4'h0);
		chk(acc_cas_period, p);
		n = 4'h0;
		while (acc_ready !== 1'b1 && n < 4'hf) begin
			@(posedge ref_clk);
			#1;
			n = n + 4'h1;
		end
		// The pin shows two flops late, so it stretches only a count still running then
		if (h != 4'h0 && !d && w >= 4'h2 && w <= h + 4'h1) chk(n, h + 4'h2);
		else chk(n, d ? {2'h0, p} : w);
		// Let the pin and its synchroniser settle before the next access
		repeat (6) @(posedge ref_clk);
		rd(4'h2, {8'h00, 1'b0, ar, 1'b0, !d && w != 4'h0, d, 1'b0});
		rd(4'h3, {4'h0, d, ar, 4'h0, d ? 4'h0 : n - w});
	endtask
	task summarize;
		if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#2000000;
		n_errors = n_errors + 1;
		summarize;
	end
	initial begin
		i = $urandom(32'h4109);
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		rd(4'h0, 16'h03f8);
		rd(4'h1, 16'h0000);
		wr(4'hf, 16'hffff);
		rd(4'hf, 16'h0000);
		for (i = 0; i < 40; i = i + 1) begin
			{c4, c3, c12, t3, t12} = 11'($urandom);
			// Early passes walk every area 3 mode/code pair and every area 4 code
			if (i < 16) {t3, c3} = i[3:0];
			if (i < 16) c4 = i[2:0];
			wr(4'h0, {6'h00, c4, c3, c12, 3'h0});
			wr(4'h1, {12'h000, t12, t3});
			rd(4'h0, {6'h00, c4, c3, c12, 3'h0});
			for (a = 1; a < 5; a = a + 1) acc(a[2:0], ($urandom % 2) ? 4'h4 : 4'h0);
		end
		summarize;
	end
endmodule

/* tb/awsc_checker.sv */
// Checker for the area wait-state controller, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module awsc_checker (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic acc_req,
	input wire logic [2:0] acc_area,
	input wire logic ext_wait_n,
	input wire logic acc_ready,
	input wire logic acc_busy,
	input wire logic [3:0] acc_waits,
	input wire logic [1:0] acc_cas_period,
	input wire logic acc_mem_dram,
	input wire logic acc_wait_honoured
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Wide enough that a long pin stretch cannot wrap it
	logic [7:0] bcnt_reg;
	always @(posedge ref_clk) begin
		if (reset || !acc_busy) bcnt_reg <= 8'h00;
		else if (clk_en) bcnt_reg <= bcnt_reg + 8'h01;
	end
	property p_rd; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
	property p_acc; acc_req && !acc_busy && clk_en && acc_area inside {[3'h1:3'h4]} |=> acc_busy; endproperty
	property p_end; acc_ready |=> !acc_busy; endproperty
	property p_stay; acc_busy && !acc_ready |=> acc_busy; endproperty
	property p_norm; acc_busy && !acc_mem_dram |-> acc_cas_period == 2'h0 &&
		acc_wait_honoured == (acc_waits != 4'h0); endproperty
	property p_dram; acc_busy && acc_mem_dram |-> !acc_wait_honoured && acc_waits == 4'h0; endproperty
	property p_dlat; acc_ready && acc_mem_dram |-> bcnt_reg == {6'h00, acc_cas_period} &&
		acc_cas_period != 2'h0; endproperty
	property p_nlat; acc_ready && !acc_mem_dram |-> bcnt_reg >= {4'h0, acc_waits}; endproperty
	a_rd: assert property (p_rd) else $error("read data outside read slot");
	a_acc: assert property (p_acc) else $error("request not taken");
	a_end: assert property (p_end) else $error("busy after ready");
	a_stay: assert property (p_stay) else $error("busy dropped without ready");
	a_norm: assert property (p_norm) else $error("normal access fields wrong");
	a_dram: assert property (p_dram) else $error("wait pin honoured for dram type");
	a_dlat: assert property (p_dlat) else $error("dram period length wrong");
	a_nlat: assert property (p_nlat) else $error("normal access ended early");
	c_dram: cover property (acc_ready && acc_mem_dram);
	c_hold: cover property (acc_busy && acc_wait_honoured && !ext_wait_n);
	c_rd: cover property (reg_rd);
endmodule
bind awsc_area_wait_ctrl awsc_checker u_chk (.*);

/* tb/awsc_mem_model.sv */
// External memory model: stretches an access by pulling the wait line low.
// Assumes start is a one-cycle pulse on ref_clk beside the request.
`timescale 1ns/100ps
module awsc_mem_model (
	input wire logic ref_clk,
	input wire logic start,
	input wire logic [3:0] hold,
	output wire logic ext_wait_n
);
	logic [3:0] left_reg = 4'h0;
	always @(posedge ref_clk) begin
		if (start) left_reg <= hold;
		else if (left_reg != 4'h0) left_reg <= left_reg - 4'h1;
	end
	// Line is driven high whenever the memory is not stretching
	assign ext_wait_n = (left_reg == 4'h0);
endmodule
